// File: rtl/lcd_driver.sv
// Serially loaded 8 x 25 multiplexed LCD driver with automatic refresh
`timescale 1ns/100ps
module lcd_driver #(
  parameter int ROWS = lcd_pkg::ROWS,
  parameter int COLS = lcd_pkg::COLS
) (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Serial host pins, asynchronous to clk
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdin,
  output logic sdout,
  output logic sdout_oe,
  // Refresh oscillator pin
  input wire logic osc,
  // Display drive, level codes in quarters of supply
  output logic [ROWS-1:0][2:0] row_lvl,
  output logic [COLS-1:0][2:0] col_lvl,
  // Status
  output logic blanked,
  output logic [2:0] last_row
);

  // Pixel buffer has no reset so power-up content is arbitrary
  logic [COLS-1:0] pix [ROWS];

  // Two-flop synchronisers for pins
  logic [1:0] cs_sync;
  logic [1:0] sclk_sync;
  logic [1:0] sdin_sync;
  logic [1:0] osc_sync;
  logic sclk_d;
  logic osc_d;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_sync <= 2'h3;
      sclk_sync <= 2'h3;
      sdin_sync <= 2'h0;
      osc_sync <= 2'h0;
      sclk_d <= 1'b1;
      osc_d <= 1'b0;
    end
    else
    begin
      cs_sync <= {cs_sync[0], cs_n};
      sclk_sync <= {sclk_sync[0], sclk};
      sdin_sync <= {sdin_sync[0], sdin};
      osc_sync <= {osc_sync[0], osc};
      sclk_d <= sclk_sync[1];
      osc_d <= osc_sync[1];
    end
  end

  logic sel;
  logic sclk_fall;
  logic osc_rise;
  // Edges come from synced copies, so a pin pulse that spans no rising clock edge is missed
  assign sel = !cs_sync[1];
  assign sclk_fall = sel && sclk_d && !sclk_sync[1];
  assign osc_rise = osc_sync[1] && !osc_d;

  // Serial frame decoder state
  lcd_pkg::lcd_state_e state;
  lcd_pkg::lcd_state_e next_state;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [2:0] row_addr;
  logic [2:0] next_row_addr;
  logic [1:0] mode;
  logic [1:0] next_mode;
  logic [COLS-1:0] shreg;
  logic [COLS-1:0] next_shreg;
  logic [2:0] next_last_row;
  logic next_blanked;
  logic next_sdout;
  logic wr_en;

  // Frame decode; deselect before the last column drops a write, but init status set after the mode bits stays
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_row_addr = row_addr;
    next_mode = mode;
    next_shreg = shreg;
    next_last_row = last_row;
    next_blanked = blanked;
    next_sdout = sdout;
    wr_en = 1'b0;
    if (!sel)
    begin
      next_state = lcd_pkg::LCD_ROWF;
      next_cnt = 5'h0;
    end
    else if (sclk_fall)
    begin
      case (state)
        lcd_pkg::LCD_ROWF:
        begin
          next_row_addr = {row_addr[1:0], sdin_sync[1]};
          next_cnt = cnt + 5'h1;
          if (cnt == 5'(lcd_pkg::ROW_W - 1))
          begin
            next_state = lcd_pkg::LCD_MODEF;
            next_cnt = 5'h0;
          end
        end
        lcd_pkg::LCD_MODEF:
        begin
          next_mode = {mode[0], sdin_sync[1]};
          next_cnt = cnt + 5'h1;
          if (cnt == 5'(lcd_pkg::MODE_W - 1))
          begin
            next_state = lcd_pkg::LCD_COLF;
            next_cnt = 5'h0;
            // Init modes take effect after the mode bits
            if (mode[0] == 1'b1)
            begin
              next_last_row = row_addr;
              next_blanked = !sdin_sync[1];
            end
            // Load the row to read, column 25 at the top
            if ({mode[0], sdin_sync[1]} == lcd_pkg::MODE_READ ||
                {mode[0], sdin_sync[1]} == lcd_pkg::MODE_INIT_VIS)
              next_shreg = pix[row_addr];
          end
        end
        lcd_pkg::LCD_COLF:
        begin
          next_cnt = cnt + 5'h1;
          if (mode[0] == 1'b0)
          begin
            // Column 1 first in, ends at bit 0
            next_shreg = {sdin_sync[1], shreg[COLS-1:1]};
            if (cnt == 5'(COLS - 1))
              wr_en = 1'b1;
          end
          else
          begin
            next_sdout = shreg[COLS-1];
            next_shreg = {shreg[COLS-2:0], 1'b0};
          end
          if (cnt == 5'(COLS - 1))
            next_state = lcd_pkg::LCD_DONE;
        end
        lcd_pkg::LCD_DONE:
        begin
          next_state = lcd_pkg::LCD_DONE;
        end
        default:
        begin
          next_state = lcd_pkg::LCD_ROWF;
        end
      endcase
    end
  end

  // Writes happen in write and blank-init modes only
  logic store;
  assign store = wr_en && (mode == lcd_pkg::MODE_WRITE || mode == lcd_pkg::MODE_INIT_BLANK);

  // Frame decoder and status registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= lcd_pkg::LCD_ROWF;
      cnt <= 5'h0;
      row_addr <= 3'h0;
      mode <= 2'h0;
      shreg <= '0;
      last_row <= lcd_pkg::LAST_ROW_RST;
      blanked <= lcd_pkg::BLANK_RST;
      sdout <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      row_addr <= next_row_addr;
      mode <= next_mode;
      shreg <= next_shreg;
      last_row <= next_last_row;
      blanked <= next_blanked;
      sdout <= next_sdout;
    end
  end

  // Buffer write port, no reset so contents survive until written
  // The word is taken after the last shift, else column 25 would be lost
  always_ff @(posedge clk)
  begin
    if (store)
      pix[row_addr] <= next_shreg;
  end

  // Output drives while selected in a reading mode and keeps driving after the
  // last bit so column 1 can still be taken; only deselect releases it
  assign sdout_oe = sel && (state == lcd_pkg::LCD_COLF || state == lcd_pkg::LCD_DONE) &&
                    mode[0] == 1'b1;

  // Refresh timing: halve oscillator, then step rows and phase
  logic half;
  logic next_half;
  logic [2:0] scan;
  logic [2:0] next_scan;
  logic phase;
  logic next_phase;

  always_comb
  begin
    next_half = half;
    next_scan = scan;
    next_phase = phase;
    if (osc_rise)
    begin
      next_half = !half;
      if (half)
      begin
        // Polarity flips each full frame to keep drive AC
        if (scan >= last_row)
        begin
          next_scan = 3'h0;
          next_phase = !phase;
        end
        else
          next_scan = scan + 3'h1;
      end
    end
  end

  // Refresh registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half <= 1'b0;
      scan <= 3'h0;
      phase <= 1'b0;
    end
    else
    begin
      half <= next_half;
      scan <= next_scan;
      phase <= next_phase;
    end
  end

  // Row whose bits go to the columns now
  logic [COLS-1:0] cur_row;
  logic [ROWS-1:0][2:0] next_row_lvl;
  logic [COLS-1:0][2:0] next_col_lvl;
  assign cur_row = pix[scan];

  // Quarter-voltage drive: selected row at a rail, others at 1/4 or 3/4
  for (genvar r = 0; r < ROWS; r++)
  begin : g_row
    always_comb
    begin
      if (r == int'(scan))
        next_row_lvl[r] = phase ? lcd_pkg::LVL_0 : lcd_pkg::LVL_100;
      else
        next_row_lvl[r] = phase ? lcd_pkg::LVL_75 : lcd_pkg::LVL_25;
    end
  end

  // Lit column opposes the row rail, unlit sits at half supply
  for (genvar c = 0; c < COLS; c++)
  begin : g_col
    always_comb
    begin
      if (cur_row[c] && !blanked)
        next_col_lvl[c] = phase ? lcd_pkg::LVL_100 : lcd_pkg::LVL_0;
      else
        next_col_lvl[c] = lcd_pkg::LVL_50;
    end
  end

  // Drive levels leave from flops; one clock of lag is far below a scan step
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      row_lvl <= {{(ROWS-1){lcd_pkg::LVL_25}}, lcd_pkg::LVL_100};
      col_lvl <= {COLS{lcd_pkg::LVL_50}};
    end
    else
    begin
      row_lvl <= next_row_lvl;
      col_lvl <= next_col_lvl;
    end
  end

endmodule

// File: rtl/lcd_pkg.sv
// Shared constants for the serial row/column LCD driver
package lcd_pkg;
  localparam int ROWS = 8;
  localparam int COLS = 25;
  localparam int ROW_W = 3;
  localparam int MODE_W = 2;
  localparam int FRAME_BITS = ROW_W + MODE_W + COLS;
  localparam logic [1:0] MODE_WRITE = 2'h0;
  localparam logic [1:0] MODE_READ = 2'h1;
  localparam logic [1:0] MODE_INIT_BLANK = 2'h2;
  localparam logic [1:0] MODE_INIT_VIS = 2'h3;
  localparam logic [2:0] LAST_ROW_RST = 3'h7;
  localparam logic BLANK_RST = 1'b1;
  // Drive level codes: fraction of supply in quarters
  localparam logic [2:0] LVL_0 = 3'h0;
  localparam logic [2:0] LVL_25 = 3'h1;
  localparam logic [2:0] LVL_50 = 3'h2;
  localparam logic [2:0] LVL_75 = 3'h3;
  localparam logic [2:0] LVL_100 = 3'h4;
  typedef enum logic [1:0] {
    LCD_ROWF = 2'b00,
    LCD_MODEF = 2'b01,
    LCD_COLF = 2'b10,
    LCD_DONE = 2'b11
  } lcd_state_e;
endpackage

// File: test/lcd_chk.sv
// Pin-level checks on the LCD driver
`timescale 1ns/100ps
module lcd_chk #(
  parameter int ROWS = 8,
  parameter int COLS = 25
) (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic sdout,
  input wire logic sdout_oe,
  // Oscillator, drive and status
  input wire logic osc,
  input wire logic [ROWS-1:0][2:0] row_lvl,
  input wire logic [COLS-1:0][2:0] col_lvl,
  input wire logic blanked,
  input wire logic [2:0] last_row
);
  logic [ROWS-1:0] sel;
  // A selected backplane sits on a rail, idle ones a quarter in
  always_comb
  begin
    for (int i = 0; i < ROWS; i++)
      sel[i] = row_lvl[i] == lcd_pkg::LVL_0 || row_lvl[i] == lcd_pkg::LVL_100;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_idle_cs;
    cs_n [*4];
  endsequence
  sequence s_idle_pins;
    ($stable(sclk) && $stable(cs_n)) [*6];
  endsequence
  a_oe_needs_cs: assert property (s_idle_cs |-> !sdout_oe)
    else $error("output enabled while deselected");
  a_status_idle: assert property (s_idle_cs |-> $stable(last_row) && $stable(blanked))
    else $error("status moved while deselected");
  a_scan_idle: assert property ($stable(osc) [*6] |-> $stable(row_lvl))
    else $error("scan moved without oscillator");
  a_sdout_hold: assert property (s_idle_pins |-> $stable(sdout))
    else $error("data out moved without clock");
  a_one_row: assert property ($onehot(sel))
    else $error("not one backplane selected");
  a_status_cause: assert property ($changed(last_row) || $changed(blanked) |-> !$past(cs_n, 3))
    else $error("status changed outside a frame");
  a_oe_after_fall: assert property ($rose(sdout_oe) |-> !$past(sclk, 2))
    else $error("output enabled off a falling clock");
  a_reset_status: assert property ($rose(rst_n) |-> last_row == 3'h7 && blanked)
    else $error("status wrong after reset");
endmodule
bind lcd_driver lcd_chk #(.ROWS(ROWS), .COLS(COLS)) u_chk (.clk(clk), .rst_n(rst_n),
  .cs_n(cs_n), .sclk(sclk), .sdin(sdin), .sdout(sdout), .sdout_oe(sdout_oe), .osc(osc),
  .row_lvl(row_lvl), .col_lvl(col_lvl), .blanked(blanked), .last_row(last_row));

// File: test/lcd_host.sv
// Host processor model for the serial pins
`timescale 1ns/100ps
module lcd_host (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic cs_n,
  output logic sclk,
  output logic sdin,
  input wire logic sdout
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b1;
    sdin = 1'b0;
  end
  // Clock idles high; a short nb cuts the frame off early
  task automatic frame(input logic [2:0] row, input logic [1:0] mode,
    input logic [24:0] cols, input int nb, output logic [24:0] rd);
    rd = 25'h0;
    @(negedge clk) cs_n = 1'b0;
    repeat (20) @(negedge clk);
    for (int i = 1; i <= nb; i++)
    begin
      sdin = i <= 3 ? row[3-i] : i <= 5 ? mode[5-i] : cols[i-6];
      repeat (2) @(negedge clk);
      sclk = 1'b0;
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (2) @(negedge clk);
      if (i >= 6)
        rd[30-i] = sdout;
    end
    repeat (6) @(negedge clk);
    cs_n = 1'b1;
    // Released data line must not look like held data
    sdin = ~sdin;
    repeat (8) @(negedge clk);
  endtask
endmodule

// File: test/tb_top.sv
// Self-checking bench for the serial LCD driver
`timescale 1ns/100ps
module tb_top;
  logic clk;
  logic rst_n;
  logic osc;
  logic cs_n, sclk, sdin, sdout, sdout_oe, blanked;
  logic [7:0][2:0] row_lvl;
  logic [24:0][2:0] col_lvl;
  logic [2:0] last_row;
  logic [24:0] mem [8];
  int m_last = 7;
  int m_blank = 1;
  int n_mismatch = 0;
  int num_checks = 0;
  integer seed = 32'he774;
  lcd_driver uut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .sdin(sdin),
    .sdout(sdout), .sdout_oe(sdout_oe), .osc(osc), .row_lvl(row_lvl), .col_lvl(col_lvl),
    .blanked(blanked), .last_row(last_row));
  // Host sees the inverse of data out whenever the driver has let go of it
  logic host_sdo;
  assign host_sdo = sdout_oe ? sdout : !sdout;
  lcd_host u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdin(sdin), .sdout(host_sdo));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Free-running refresh source, unrelated to the frames
  initial
  begin
    osc = 1'b0;
    forever
    begin
      repeat (7) @(negedge clk);
      osc = ~osc;
    end
  end
  task automatic chk(input string nm, input logic [24:0] exp, input logic [24:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Column 1 always lit and column 2 always dark, so on and off show on the pins
  task automatic xfer(input logic [2:0] row, input logic [1:0] mode, input int nb);
    logic [24:0] d;
    logic [24:0] q;
    d = (25'($random(seed)) | 25'h1) & ~25'h2;
    u_host.frame(row, mode, d, nb, q);
    if (nb == 30 && !mode[0])
      mem[row] = d;
    if (mode[1])
    begin
      m_last = row;
      m_blank = !mode[0];
    end
    if (nb == 30 && mode[0])
      chk("read row", mem[row], q);
    chk("last_row", 25'(m_last), 25'(last_row));
    chk("blanked", 25'(m_blank), 25'(blanked));
  endtask
  initial
  begin
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    xfer(3'h7, lcd_pkg::MODE_INIT_BLANK, 30);
    for (int r = 0; r < 7; r++)
      xfer(3'(r), lcd_pkg::MODE_WRITE, 30);
    chk("blank col 1", 25'(lcd_pkg::LVL_50), 25'(col_lvl[0]));
    xfer(3'h7, lcd_pkg::MODE_INIT_VIS, 30);
    for (int r = 0; r < 8; r++)
      xfer(3'(r), lcd_pkg::MODE_READ, 30);
    repeat (40) @(negedge clk);
    chk("dark col 2", 25'(lcd_pkg::LVL_50), 25'(col_lvl[1]));
    num_checks++;
    if (col_lvl[0] === col_lvl[1])
    begin
      $display("wrong value on column expected not %h seen %h", col_lvl[1], col_lvl[0]);
      n_mismatch++;
    end
    xfer(3'h3, lcd_pkg::MODE_WRITE, 15);
    xfer(3'h3, lcd_pkg::MODE_READ, 30);
    xfer(3'h3, lcd_pkg::MODE_INIT_VIS, 5);
    xfer(3'h5, lcd_pkg::MODE_INIT_BLANK, 30);
    xfer(3'h5, lcd_pkg::MODE_READ, 30);
    tally_and_finish;
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
